// [common/color_sensor_consts.svh]
// Register addresses, field positions and reset values of the colour sensor register bank.
`ifndef COLOR_SENSOR_CONSTS_SVH
`define COLOR_SENSOR_CONSTS_SVH

`define CS_ADDR_W 8
`define CS_DATA_W 8
`define CS_CHANNELS 4
`define CS_RES_W 10
`define CS_SLOTS_W 12

`define CS_ADDR_CTRL 8'h00
`define CS_ADDR_CONFIG 8'h01
`define CS_ADDR_SLOTS_LO 8'h10
`define CS_ADDR_SLOTS_HI 8'h11
`define CS_ADDR_RES_BASE 8'h40
`define CS_ADDR_RES_LAST 8'h47
`define CS_ADDR_OFS_BASE 8'h48
`define CS_ADDR_OFS_LAST 8'h4B

`define CS_CTRL_SAMPLE_BIT 5
`define CS_CTRL_OFFSET_BIT 6
`define CS_CFG_TRIM_BIT 0
`define CS_CFG_SLEEP_BIT 1
`define CS_CFG_EXTCLK_BIT 2

`define CS_SIGN_BIT 7
`define CS_LO_MSB 7
`define CS_HI_LSB 8
`define CS_HI_MSB 9
`define CS_SLOTS_HI_MSB 11
`define CS_NIBBLE_MSB 3
`define CS_HI_PAD_W 6
`define CS_NIBBLE_PAD_W 4
`define CS_CFG_PAD_W 5

`define CS_BYTE_ZERO 8'h00
`define CS_SLOTS_RESET 12'h000
`define CS_HI_RESET 2'h0
`define CS_CFG_RESET 3'h0

`endif

// [common/color_sensor_pkg.sv]
// Types shared by the colour sensor register bank.
package color_sensor_pkg;

  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_SAMPLE,
    CONV_OFFSET
  } conv_state_t;

endpackage : color_sensor_pkg

// [hw/color_sensor_result_registers.sv]
// Control, integration-slot, result and offset registers of the colour sensor.
`timescale 1ns/1ps
`include "color_sensor_consts.svh"
// Notes on behaviour
// - Clear-channel slot count is 12 bits: low byte, then bits 11:8 in low nibble.
// - Each channel result is 10 bits: low byte, bits 9:8 in high register bits 1:0.
// - Red, green, blue and clear each own one low and one high result register.
// - High result registers read zero in bits 7 to 2.
// - Offset register bit 7 is polarity: 0 positive, 1 negative.
// - Offset magnitude is seven bits 6:0, one offset register per channel.
// - Sample trigger starts conversion, self-clears, results land at addresses 64 to 71.
// - Offset trigger starts offset measurement, self-clears, offsets land at 72 to 75.
// - Offset trim mode bit is stored and driven out on offsetTrimMode_q; no logic here applies offset trimming.
module color_sensor_result_registers (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`CS_ADDR_W-1:0] regAddr,
  input wire logic [`CS_DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [`CS_DATA_W-1:0] regRdata_q,
  output logic sampleStart_q,
  output logic offsetStart_q,
  input wire logic resultDone,
  input wire logic [`CS_RES_W-1:0] redResult,
  input wire logic [`CS_RES_W-1:0] greenResult,
  input wire logic [`CS_RES_W-1:0] blueResult,
  input wire logic [`CS_RES_W-1:0] clearResult,
  input wire logic offsetDone,
  input wire logic [`CS_DATA_W-1:0] redOffset,
  input wire logic [`CS_DATA_W-1:0] greenOffset,
  input wire logic [`CS_DATA_W-1:0] blueOffset,
  input wire logic [`CS_DATA_W-1:0] clearOffset,
  output logic offsetTrimMode_q,
  output logic sleepMode_q,
  output logic extClockMode_q,
  output logic [`CS_SLOTS_W-1:0] clearSlots_q
);

  color_sensor_pkg::conv_state_t state_q;
  color_sensor_pkg::conv_state_t state_d;
  logic sampleTrig_q;
  logic offsetTrig_q;
  logic [`CS_RES_W-1:0] resIn [`CS_CHANNELS];
  logic [`CS_DATA_W-1:0] ofsIn [`CS_CHANNELS];
  logic [`CS_DATA_W-1:0] resLo_q [`CS_CHANNELS];
  logic [1:0] resHi_q [`CS_CHANNELS];
  logic [`CS_DATA_W-1:0] ofs_q [`CS_CHANNELS];

  wire logic ctrlWrite = regWrite && (regAddr == `CS_ADDR_CTRL);
  wire logic cfgWrite = regWrite && (regAddr == `CS_ADDR_CONFIG);
  wire logic slotsLoWrite = regWrite && (regAddr == `CS_ADDR_SLOTS_LO);
  wire logic slotsHiWrite = regWrite && (regAddr == `CS_ADDR_SLOTS_HI);
  wire logic sampleSet = ctrlWrite && regWdata[`CS_CTRL_SAMPLE_BIT];
  wire logic offsetSet = ctrlWrite && regWdata[`CS_CTRL_OFFSET_BIT];
  wire logic captureRes = (state_q == color_sensor_pkg::CONV_SAMPLE) && resultDone;
  wire logic captureOfs = (state_q == color_sensor_pkg::CONV_OFFSET) && offsetDone;
  wire logic startSample = (state_q == color_sensor_pkg::CONV_IDLE) && sampleTrig_q;
  wire logic startOffset = (state_q == color_sensor_pkg::CONV_IDLE) && !sampleTrig_q
                           && offsetTrig_q;
  // Built in a process so that it follows every register the decoder reads, not just the address.
  logic [`CS_DATA_W-1:0] readValue;

  assign resIn[0] = redResult;
  assign resIn[1] = greenResult;
  assign resIn[2] = blueResult;
  assign resIn[3] = clearResult;
  assign ofsIn[0] = redOffset;
  assign ofsIn[1] = greenOffset;
  assign ofsIn[2] = blueOffset;
  assign ofsIn[3] = clearOffset;

  // Unmapped addresses read as zero; reserved bits read as zero.
  function automatic logic [`CS_DATA_W-1:0] readMux(input logic [`CS_ADDR_W-1:0] a);
    logic [`CS_DATA_W-1:0] v;
    v = `CS_BYTE_ZERO;
    if (a == `CS_ADDR_CTRL)
    begin
      v[`CS_CTRL_SAMPLE_BIT] = sampleTrig_q;
      v[`CS_CTRL_OFFSET_BIT] = offsetTrig_q;
    end
    else if (a == `CS_ADDR_CONFIG)
      v = {{`CS_CFG_PAD_W{1'b0}}, extClockMode_q, sleepMode_q, offsetTrimMode_q};
    else if (a == `CS_ADDR_SLOTS_LO)
      v = clearSlots_q[`CS_LO_MSB:0];
    else if (a == `CS_ADDR_SLOTS_HI)
      v = {{`CS_NIBBLE_PAD_W{1'b0}}, clearSlots_q[`CS_SLOTS_HI_MSB:`CS_HI_LSB]};
    else if (a >= `CS_ADDR_RES_BASE && a <= `CS_ADDR_RES_LAST)
    begin
      if (a[0])
        v = {{`CS_HI_PAD_W{1'b0}}, resHi_q[a[2:1]]};
      else
        v = resLo_q[a[2:1]];
    end
    else if (a >= `CS_ADDR_OFS_BASE && a <= `CS_ADDR_OFS_LAST)
      v = ofs_q[a[1:0]];
    return v;
  endfunction : readMux

  always_comb
  begin
    readValue = readMux(regAddr);
  end

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      color_sensor_pkg::CONV_IDLE:
      begin
        if (startSample)
          state_d = color_sensor_pkg::CONV_SAMPLE;
        else if (startOffset)
          state_d = color_sensor_pkg::CONV_OFFSET;
      end
      color_sensor_pkg::CONV_SAMPLE:
      begin
        if (resultDone)
          state_d = color_sensor_pkg::CONV_IDLE;
      end
      color_sensor_pkg::CONV_OFFSET:
      begin
        if (offsetDone)
          state_d = color_sensor_pkg::CONV_IDLE;
      end
      default:
        state_d = color_sensor_pkg::CONV_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= color_sensor_pkg::CONV_IDLE;
      sampleStart_q <= 1'b0;
      offsetStart_q <= 1'b0;
      regRdata_q <= `CS_BYTE_ZERO;
    end
    else
    begin
      state_q <= state_d;
      sampleStart_q <= startSample;
      offsetStart_q <= startOffset;
      if (regRead)
        regRdata_q <= readValue;
    end
  end

  // A new host request in the completion cycle wins over the automatic clear.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sampleTrig_q <= 1'b0;
      offsetTrig_q <= 1'b0;
    end
    else
    begin
      sampleTrig_q <= sampleSet || (sampleTrig_q && !captureRes);
      offsetTrig_q <= offsetSet || (offsetTrig_q && !captureOfs);
    end
  end

  // Sleep holds only while external clock mode is selected.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      {extClockMode_q, sleepMode_q, offsetTrimMode_q} <= `CS_CFG_RESET;
      clearSlots_q <= `CS_SLOTS_RESET;
    end
    else
    begin
      if (cfgWrite)
      begin
        offsetTrimMode_q <= regWdata[`CS_CFG_TRIM_BIT];
        extClockMode_q <= regWdata[`CS_CFG_EXTCLK_BIT];
        sleepMode_q <= regWdata[`CS_CFG_SLEEP_BIT] && regWdata[`CS_CFG_EXTCLK_BIT];
      end
      if (slotsLoWrite)
        clearSlots_q[`CS_LO_MSB:0] <= regWdata;
      if (slotsHiWrite)
        clearSlots_q[`CS_SLOTS_HI_MSB:`CS_HI_LSB] <= regWdata[`CS_NIBBLE_MSB:0];
    end
  end

  for (genvar ch = 0; ch < `CS_CHANNELS; ch++)
  begin : g_chan
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        resLo_q[ch] <= `CS_BYTE_ZERO;
        resHi_q[ch] <= `CS_HI_RESET;
        ofs_q[ch] <= `CS_BYTE_ZERO;
      end
      else
      begin
        if (captureRes)
        begin
          resLo_q[ch] <= resIn[ch][`CS_LO_MSB:0];
          resHi_q[ch] <= resIn[ch][`CS_HI_MSB:`CS_HI_LSB];
        end
        if (captureOfs)
          ofs_q[ch] <= ofsIn[ch];
      end
    end
  end

  a_slots_high: assert property (@(posedge clk) disable iff (rst)
    regRead && regAddr == `CS_ADDR_SLOTS_HI |=>
    regRdata_q == {4'h0, $past(clearSlots_q[11:8])})
    else $error("Slot count high nibble read wrong.");
  a_result_split: assert property (@(posedge clk) disable iff (rst)
    captureRes |=> resLo_q[0] == $past(redResult[7:0]) && resHi_q[3] == $past(clearResult[9:8]))
    else $error("Result not split into low and high bytes.");
  a_result_low: assert property (@(posedge clk) disable iff (rst)
    regRead && regAddr == 8'h44 |=> regRdata_q == $past(resLo_q[2]))
    else $error("Blue low byte read wrong.");
  a_high_pad: assert property (@(posedge clk) disable iff (rst)
    regRead && regAddr >= 8'h40 && regAddr <= 8'h47 && regAddr[0] |=> regRdata_q[7:2] == 6'h00)
    else $error("High result register upper bits not zero.");
  a_offset_sign: assert property (@(posedge clk) disable iff (rst)
    regRead && regAddr == 8'h4B |=> regRdata_q[7] == $past(ofs_q[3][7]))
    else $error("Offset polarity flag not at bit 7.");
  a_offset_mag: assert property (@(posedge clk) disable iff (rst)
    captureOfs |=> ofs_q[1][6:0] == $past(greenOffset[6:0]))
    else $error("Offset magnitude not captured.");
  a_sample_flow: assert property (@(posedge clk) disable iff (rst)
    startSample |=> sampleStart_q && state_q == color_sensor_pkg::CONV_SAMPLE)
    else $error("Sample trigger did not start a conversion.");
  a_sample_clear: assert property (@(posedge clk) disable iff (rst)
    captureRes && !sampleSet |=> !sampleTrig_q)
    else $error("Sample trigger not cleared on completion.");
  a_offset_clear: assert property (@(posedge clk) disable iff (rst)
    captureOfs && !offsetSet |=> !offsetTrig_q && state_q == color_sensor_pkg::CONV_IDLE)
    else $error("Offset trigger not cleared on completion.");
  a_trim_mode: assert property (@(posedge clk) disable iff (rst)
    cfgWrite |=> offsetTrimMode_q == $past(regWdata[0]))
    else $error("Trim mode not taken from configuration write.");

endmodule : color_sensor_result_registers

// [verification/color_sensor_result_registers_bench.sv]
// Self-checking bench for the colour sensor result register bank.
`timescale 1ns/1ps
`include "color_sensor_consts.svh"
module color_sensor_result_registers_bench;
  localparam logic [39:0] RES = {10'h3A5, 10'h15A, 10'h2C3, 10'h0FF};
  localparam logic [31:0] OFS = {8'h7F, 8'hFF, 8'h12, 8'h85};
  logic clk = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata_q, rd;
  logic sampleStart_q, offsetStart_q, resultDone, offsetDone;
  logic offsetTrimMode_q, sleepMode_q, extClockMode_q;
  logic [11:0] clearSlots_q;
  logic [39:0] results;
  logic [31:0] offsets;
  int n_fail = 0, total_checks = 0;
  color_sensor_result_registers i_color_sensor_result_registers (.clk(clk), .rst(rst),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata_q(regRdata_q), .sampleStart_q(sampleStart_q), .offsetStart_q(offsetStart_q),
    .resultDone(resultDone), .redResult(results[9:0]), .greenResult(results[19:10]),
    .blueResult(results[29:20]), .clearResult(results[39:30]), .offsetDone(offsetDone),
    .redOffset(offsets[7:0]), .greenOffset(offsets[15:8]), .blueOffset(offsets[23:16]),
    .clearOffset(offsets[31:24]), .offsetTrimMode_q(offsetTrimMode_q),
    .sleepMode_q(sleepMode_q), .extClockMode_q(extClockMode_q), .clearSlots_q(clearSlots_q));
  conv_engine_model #(.RES(RES), .OFS(OFS), .DELAY(6)) i_conv_engine_model (.clk(clk),
    .sampleStart(sampleStart_q), .offsetStart(offsetStart_q), .resultDone(resultDone),
    .offsetDone(offsetDone), .results(results), .offsets(offsets));
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge clk);
    regWrite = 1'b0;
  endtask : wr
  task automatic rdreg(input logic [7:0] a);
    @(negedge clk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clk);
    regRead = 1'b0;
    @(negedge clk);
    rd = regRdata_q;
  endtask : rdreg
  task automatic trigger_and_wait(input logic [7:0] mask);
    int n;
    wr(`CS_ADDR_CTRL, mask);
    n = 0;
    // Results are read once the trigger bit has dropped or after 40 polls.
    do
    begin
      rdreg(`CS_ADDR_CTRL);
      n++;
    end
    while ((rd & mask) !== 8'h00 && n < 40);
    check(rd & mask, 12'h000);
  endtask : trigger_and_wait
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    #100000;
    n_fail++;
    tally_and_finish;
  end
  initial
  begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rdreg(`CS_ADDR_SLOTS_HI);
    check(rd, 12'h000);
    wr(`CS_ADDR_SLOTS_LO, 8'hA5);
    wr(`CS_ADDR_SLOTS_HI, 8'hFB);
    check(clearSlots_q, 12'hBA5);
    rdreg(`CS_ADDR_SLOTS_HI);
    check(rd, 12'h00B);
    trigger_and_wait(8'h20);
    for (int k = 0; k < 4; k++)
    begin
      rdreg(8'h40 + 8'(2 * k));
      check(rd, {4'h0, RES[k*10 +: 8]});
      rdreg(8'h41 + 8'(2 * k));
      check(rd, {10'h000, RES[k*10+8 +: 2]});
    end
    trigger_and_wait(8'h40);
    for (int k = 0; k < 4; k++)
    begin
      rdreg(8'h48 + 8'(k));
      check(rd, {4'h0, OFS[k*8 +: 8]});
    end
    wr(8'h40, 8'h11);
    rdreg(8'h40);
    check(rd, {4'h0, RES[7:0]});
    rdreg(8'hF0);
    check(rd, 12'h000);
    wr(`CS_ADDR_CONFIG, 8'h01);
    check(offsetTrimMode_q, 12'h001);
    rdreg(`CS_ADDR_CONFIG);
    check(rd, 12'h001);
    wr(`CS_ADDR_CONFIG, 8'h06);
    check({sleepMode_q, extClockMode_q}, 12'h003);
    wr(`CS_ADDR_CONFIG, 8'h02);
    check({sleepMode_q, extClockMode_q}, 12'h000);
    wr(`CS_ADDR_CONFIG, 8'h00);
    check(offsetTrimMode_q, 12'h000);
    tally_and_finish;
  end
endmodule : color_sensor_result_registers_bench

// [verification/conv_engine_model.sv]
// Behavioural model of the conversion engine that answers start pulses with done pulses.
`timescale 1ns/1ps
module conv_engine_model #(
  parameter logic [39:0] RES = 40'h0,
  parameter logic [31:0] OFS = 32'h0,
  parameter int DELAY = 5
) (
  input wire logic clk,
  input wire logic sampleStart,
  input wire logic offsetStart,
  output logic resultDone,
  output logic offsetDone,
  output logic [39:0] results,
  output logic [31:0] offsets
);
  // Outside the done cycle the data shows the inverse so a stale capture stands out.
  initial
  begin
    resultDone = 1'b0;
    offsetDone = 1'b0;
    results = ~RES;
    offsets = ~OFS;
    forever
    begin
      @(posedge clk);
      if (sampleStart === 1'b1)
      begin
        repeat (DELAY) @(posedge clk);
        results <= RES;
        resultDone <= 1'b1;
        @(posedge clk);
        resultDone <= 1'b0;
        results <= ~RES;
      end
      else if (offsetStart === 1'b1)
      begin
        repeat (DELAY) @(posedge clk);
        offsets <= OFS;
        offsetDone <= 1'b1;
        @(posedge clk);
        offsetDone <= 1'b0;
        offsets <= ~OFS;
      end
    end
  end
endmodule : conv_engine_model
